/* File: hdl/palc_link_controller.sv */
// interface board logic between two pixel asics and the host link
`timescale 1ns/10ps
`include "palc_params.svh"
module palc_link_controller
   import palc_pkg::*;
#(
   parameter int READ_WORDS = `PALC_READ_WORDS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // host link inputs, asynchronous
   input wire logic hkClk,
   input wire logic hkEnable,
   input wire logic hkOutgoingData,
   input wire logic readPulse,
   input wire logic shutter,
   input wire logic countClock,
   input wire logic [1:0] asicIdBit,
   // host link outputs
   output logic hkReturnData,
   output logic [`PALC_LANES-1:0] pixelDataLanes,
   output logic pixelParity,
   output logic pixelSync,
   output logic pixelDdrClock,
   // asic pixel stream, same clock
   input wire logic [`PALC_LANES-1:0] asicPixelPair,
   input wire logic asicPixelValid,
   output logic asicPixelReady,
   // asic control
   output logic [1:0] asicMode,
   output logic [1:0] frameClockHigh,
   output logic [1:0] frameClockLow,
   output logic [1:0] asicInputEnable,
   output logic [1:0] asicDataIn,
   output logic asicShutter,
   output logic countPolarity,
   output logic testPulseEnable,
   // housekeeping side
   output logic [2:0] dacChannel,
   output logic [9:0] dacValue,
   output logic dacWrite,
   output logic [1:0] adcChannel,
   output logic adcRequest,
   output logic tempRequest,
   input wire logic [11:0] adcValue,
   input wire logic [15:0] tempValue,
   output logic ledD2,
   output logic ledD3
);
   localparam int AW = `PALC_FIFO_AW;
   localparam int WB = `PALC_WORD_CNT_BITS;

   typedef struct packed {
      logic [7:0] inA;
      logic [7:0] inB;
      logic [7:0] inC;
      palc_state_t state;
      logic pass;
      logic sel;
      logic [15:0] shift;
      logic [`PALC_CNT_BITS-1:0] bitCnt;
      logic [15:0] ret;
      logic hkRet;
      logic count_polarity;
      logic tp;
      logic ledEn;
      logic ledA;
      logic ledB;
      logic [2:0] dacCh;
      logic [9:0] dacVal;
      logic dacWr;
      logic [1:0] adcCh;
      logic adcReq;
      logic tempReq;
      logic [1:0] mode;
      logic [1:0] fHi;
      logic [1:0] fLo;
      logic [1:0] inEn;
      logic [1:0] dIn;
      logic shut;
      logic [WB-1:0] wordCnt;
      logic first;
      logic [(1<<AW)-1:0][`PALC_LANES+1:0] mem;
      logic [AW:0] wrPtr;
      logic [AW:0] rdPtr;
      logic [`PALC_LANES-1:0] lanes;
      logic par;
      logic sync;
      logic ddr;
   } palc_regs_t;

   palc_regs_t q;
   palc_regs_t next_q;
   logic [1:0] rstSync;
   logic rstInt_b;

   // decode of the command word, used by logic and checks
   function automatic palc_cmd_t cmdKind(input logic [15:0] w);
      palc_cmd_t k;
      k = PALC_CMD_NONE;
      if (w[15:13] == `PALC_OP_DAC) begin
         k = PALC_CMD_DAC;
      end else if (w[15:13] == 3'h0) begin
         case (w[15:10])
            `PALC_OP_COUNT: k = PALC_CMD_COUNT;
            `PALC_OP_LOAD: k = PALC_CMD_LOAD;
            `PALC_OP_FSR: k = PALC_CMD_FSR;
            `PALC_OP_ADC: k = PALC_CMD_ADC;
            `PALC_OP_TEMP: k = PALC_CMD_TEMP;
            `PALC_OP_LED: k = PALC_CMD_LED;
            default: k = PALC_CMD_NONE;
         endcase
      end
      return k;
   endfunction

   // edges of synchronised inputs, taken from stages two and three
   logic sRise;
   logic sFall;
   logic enFall;
   logic readRise;
   logic fifoEmpty;
   logic fifoFull;
   logic push;
   logic pop;
   logic cmdDone;
   assign sRise = q.inB[0] & ~q.inC[0];
   assign sFall = ~q.inB[0] & q.inC[0];
   assign enFall = ~q.inB[1] & q.inC[1];
   assign readRise = q.inB[3] & ~q.inC[3];
   assign fifoEmpty = q.wrPtr == q.rdPtr;
   assign fifoFull = q.wrPtr == {~q.rdPtr[AW], q.rdPtr[AW-1:0]};
   assign cmdDone = enFall & ~q.pass & (q.bitCnt == 5'h10);
   // capture limited to the dump length; ready stalls the asic stream
   assign asicPixelReady = (q.state == PALC_ST_READ) & ~fifoFull
      & (q.wordCnt < WB'(READ_WORDS));
   assign push = asicPixelReady & asicPixelValid;
   assign pop = ~fifoEmpty;

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstInt_b = rstSync[1];

   always_comb begin
      next_q = q;
      next_q.inA = {asicIdBit, countClock, shutter, readPulse,
         hkOutgoingData, hkEnable, hkClk};
      next_q.inB = q.inA;
      next_q.inC = q.inB;
      next_q.dacWr = 1'b0;
      next_q.adcReq = 1'b0;
      next_q.tempReq = 1'b0;
      // serial receive: shift on rising serial clock while enabled
      if (sRise && q.inB[1] && !q.pass) begin
         next_q.shift = {q.shift[14:0], q.inB[2]};
         if (q.bitCnt != 5'h10) begin
            next_q.bitCnt = q.bitCnt + 5'h01;
         end
      end
      // return data moves on the falling serial clock
      if (sFall && q.inB[1] && q.state != PALC_ST_FSR) begin
         next_q.hkRet = q.ret[15];
         next_q.ret = {q.ret[14:0], 1'b0};
      end
      if (q.state == PALC_ST_FSR) begin
         next_q.hkRet = q.inB[6 + 32'(q.sel)];
      end
      // commands act only on the falling edge of the enable
      if (enFall) begin
         next_q.bitCnt = '0;
         if (q.pass) begin
            next_q.pass = 1'b0;
            next_q.state = PALC_ST_COUNT;
         end
      end
      if (cmdDone) begin
         case (cmdKind(q.shift))
            PALC_CMD_COUNT: begin
               next_q.state = PALC_ST_COUNT;
               next_q.count_polarity = q.shift[`PALC_BIT_A];
               next_q.tp = q.shift[`PALC_BIT_B];
            end
            PALC_CMD_LOAD: begin
               next_q.state = PALC_ST_LOAD;
               next_q.pass = 1'b1;
               next_q.sel = q.shift[`PALC_BIT_A];
            end
            PALC_CMD_FSR: begin
               next_q.state = PALC_ST_FSR;
               next_q.pass = 1'b1;
               next_q.sel = q.shift[`PALC_BIT_A];
            end
            PALC_CMD_ADC: begin
               next_q.adcCh = q.shift[9:8];
               next_q.adcReq = 1'b1;
               // msb stands before the first rising serial clock
               next_q.ret = {3'h0, adcValue, 1'b0};
               next_q.hkRet = 1'b0;
            end
            PALC_CMD_TEMP: begin
               next_q.tempReq = 1'b1;
               next_q.ret = {tempValue[14:0], 1'b0};
               next_q.hkRet = tempValue[15];
            end
            PALC_CMD_LED: begin
               next_q.ledEn = q.shift[`PALC_BIT_A];
               next_q.ledA = q.shift[`PALC_BIT_B];
               next_q.ledB = q.shift[`PALC_BIT_LEDB];
            end
            PALC_CMD_DAC: begin
               next_q.dacCh = q.shift[12:10];
               next_q.dacVal = q.shift[9:0];
               next_q.dacWr = 1'b1;
            end
            default: begin
               next_q.state = q.state;
            end
         endcase
      end
      // readout start and finish
      if (q.state == PALC_ST_COUNT && readRise) begin
         next_q.state = PALC_ST_READ;
         next_q.wordCnt = '0;
         next_q.first = 1'b1;
      end
      if (push) begin
         // sync flags the first word of a dump, parity is even
         next_q.mem[q.wrPtr[AW-1:0]] = {q.first,
            ^asicPixelPair, asicPixelPair};
         next_q.wrPtr = q.wrPtr + 1'b1;
         next_q.wordCnt = q.wordCnt + 1'b1;
         next_q.first = 1'b0;
      end
      if (q.state == PALC_ST_READ && fifoEmpty
            && q.wordCnt == WB'(READ_WORDS)) begin
         next_q.state = PALC_ST_COUNT;
      end
      // drain one word per edge of the data clock
      if (pop) begin
         {next_q.sync, next_q.par, next_q.lanes} =
            q.mem[q.rdPtr[AW-1:0]];
         next_q.rdPtr = q.rdPtr + 1'b1;
         next_q.ddr = ~q.ddr;
      end else begin
         next_q.sync = 1'b0;
      end
      // mode lines and clock routing follow the next state
      next_q.inEn = 2'h0;
      next_q.dIn = 2'h0;
      next_q.shut = 1'b0;
      case (next_q.state)
         PALC_ST_COUNT: begin
            next_q.mode = `PALC_MODE_COUNT;
            next_q.fHi = {2{q.inB[5]}};
            next_q.fLo = {2{q.inB[5]}};
            next_q.shut = q.inB[4];
         end
         PALC_ST_READ: begin
            // high then low in one cycle gives a 100 MHz frame clock
            next_q.mode = `PALC_MODE_READ;
            next_q.fHi = 2'h3;
            next_q.fLo = 2'h0;
         end
         default: begin
            next_q.mode = (next_q.state == PALC_ST_FSR) ?
               `PALC_MODE_FSR : `PALC_MODE_LOAD;
            next_q.fHi = 2'h0;
            next_q.fLo = 2'h0;
            if (next_q.pass) begin
               next_q.fHi[next_q.sel] = q.inB[0];
               next_q.fLo[next_q.sel] = q.inB[0];
               next_q.inEn[next_q.sel] = q.inB[1];
               next_q.dIn[next_q.sel] = q.inB[2];
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstInt_b) begin
      if (!rstInt_b) begin
         q <= '0;
         q.mode <= `PALC_MODE_COUNT;
      end else begin
         q <= next_q;
      end
   end

   // outputs straight from registers
   assign hkReturnData = q.hkRet;
   assign pixelDataLanes = q.lanes;
   assign pixelParity = q.par;
   assign pixelSync = q.sync;
   assign pixelDdrClock = q.ddr;
   assign asicMode = q.mode;
   assign frameClockHigh = q.fHi;
   assign frameClockLow = q.fLo;
   assign asicInputEnable = q.inEn;
   assign asicDataIn = q.dIn;
   assign asicShutter = q.shut;
   assign countPolarity = q.count_polarity;
   assign testPulseEnable = q.tp;
   assign dacChannel = q.dacCh;
   assign dacValue = q.dacVal;
   assign dacWrite = q.dacWr;
   assign adcChannel = q.adcCh;
   assign adcRequest = q.adcReq;
   assign tempRequest = q.tempReq;
   // leds show readout and integration unless commanded
   assign ledD2 = q.ledEn ? q.ledA : (q.state == PALC_ST_READ);
   assign ledD3 = q.ledEn ? q.ledB : q.shut;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstInt_b);

   sequence seqReadGo;
      q.state == PALC_ST_COUNT && readRise;
   endsequence
   sequence seqReadOn;
      q.mode == `PALC_MODE_READ && q.fHi == 2'h3 && q.fLo == 2'h0;
   endsequence

   AST_CMD_FULL: assert property (
      $rose(dacWrite) |-> $past(q.bitCnt) == 5'h10)
      else $error("dac written before 16 bits");
   AST_COUNT_CMD: assert property (
      cmdDone && cmdKind(q.shift) == PALC_CMD_COUNT |=>
      countPolarity == $past(q.shift[9]) && asicMode == 2'h3)
      else $error("count command not applied");
   AST_LOAD_ROUTE: assert property (
      q.state == PALC_ST_LOAD && q.pass && !q.sel |=>
      q.state != PALC_ST_LOAD || asicInputEnable[0] == $past(q.inB[1]))
      else $error("matrix enable not routed");
   AST_FSR_MODE: assert property (
      $rose(q.state == PALC_ST_FSR) |-> asicMode == 2'h1)
      else $error("fsr mode lines wrong");
   AST_DAC_VAL: assert property (
      dacWrite |-> dacValue == $past(q.shift[9:0]))
      else $error("dac value mismatch");
   AST_COUNT_MODE: assert property (
      q.state == PALC_ST_COUNT |-> asicMode == 2'h3)
      else $error("counting mode bits wrong");
   AST_READ_START: assert property (
      seqReadGo |=> seqReadOn)
      else $error("readout did not start");
   AST_READ_END: assert property (
      q.state == PALC_ST_READ ##1 q.state == PALC_ST_COUNT |->
      asicMode == 2'h3)
      else $error("mode not restored after readout");
   AST_PARITY: assert property (
      $changed(pixelDdrClock) |-> pixelParity == ^pixelDataLanes)
      else $error("parity wrong");
   // word count restarts at each read start, so zero marks the first push
   AST_SYNC_FIRST: assert property (
      push && q.wordCnt == '0 |=>
      q.mem[$past(q.wrPtr[AW-1:0])][`PALC_LANES+1])
      else $error("first word lacks sync");
   AST_SYNC_LATER: assert property (
      push && q.wordCnt != '0 |=>
      !q.mem[$past(q.wrPtr[AW-1:0])][`PALC_LANES+1])
      else $error("later word carries sync");
endmodule

/* File: hdl/palc_params.svh */
// constants for the pixel asic link controller
`ifndef PALC_PARAMS_SVH
`define PALC_PARAMS_SVH
`define PALC_CMD_BITS 16
`define PALC_CNT_BITS 5
`define PALC_OP_COUNT 6'h00
`define PALC_OP_ADC 6'h03
`define PALC_OP_TEMP 6'h04
`define PALC_OP_LED 6'h05
`define PALC_OP_LOAD 6'h01
`define PALC_OP_FSR 6'h02
`define PALC_OP_DAC 3'h1
`define PALC_BIT_A 9
`define PALC_BIT_B 8
`define PALC_BIT_LEDB 7
`define PALC_MODE_COUNT 2'h3
`define PALC_MODE_READ 2'h0
`define PALC_MODE_FSR 2'h1
`define PALC_MODE_LOAD 2'h2
`define PALC_LANES 28
`define PALC_FIFO_AW 4
`define PALC_READ_WORDS 65536
`define PALC_WORD_CNT_BITS 17
`endif

/* File: hdl/palc_pkg.sv */
// types for the pixel asic link controller
package palc_pkg;
   typedef enum logic [1:0] {
      PALC_ST_COUNT = 2'b00,
      PALC_ST_READ = 2'b01,
      PALC_ST_LOAD = 2'b10,
      PALC_ST_FSR = 2'b11
   } palc_state_t;
   typedef enum logic [2:0] {
      PALC_CMD_COUNT = 3'b000,
      PALC_CMD_LOAD = 3'b001,
      PALC_CMD_FSR = 3'b010,
      PALC_CMD_ADC = 3'b011,
      PALC_CMD_TEMP = 3'b100,
      PALC_CMD_LED = 3'b101,
      PALC_CMD_DAC = 3'b110,
      PALC_CMD_NONE = 3'b111
   } palc_cmd_t;
endpackage

/* File: verification/palc_host_model.sv */
// host side model: serial link, read pulse, shutter and count clock
`timescale 1ns/10ps
module palc_host_model (
   // clock
   input wire logic clk,
   // serial housekeeping link
   output logic hkClk,
   output logic hkEnable,
   output logic hkOutgoingData,
   input wire logic hkReturnData,
   // acquisition control
   output logic readPulse,
   output logic shutter,
   output logic countClock
);
   // quiet link at time zero, link clock idles low
   initial begin
      hkClk = 1'b0;
      hkEnable = 1'b0;
      hkOutgoingData = 1'b0;
      readPulse = 1'b0;
      shutter = 1'b0;
   end
   // free running count clock, 80 ns period
   initial begin
      countClock = 1'b0;
      forever begin
         repeat (4) @(posedge clk);
         countClock <= ~countClock;
      end
   end
   // shutter table walk; an all zero entry ends the list
   task automatic run_table(input logic [1:0] m,
                            input logic [2:0][31:0] tbl);
      for (int i = 0; i < 3; i++) begin
         if (tbl[i] == 32'h0000_0000) begin
            break;
         end
         if (m == 2'h1) begin
            // single frame: open time in the upper half of entry 0
            set_shutter(1'b1);
            repeat (tbl[i][31:16]) @(posedge clk);
            set_shutter(1'b0);
            break;
         end
         // let a previous sparse dump finish before the next window
         if (m == 2'h3 && i > 0) begin
            repeat (40) @(posedge clk);
         end
         repeat (tbl[i][31:16]) @(posedge clk);
         set_shutter(1'b1);
         repeat (tbl[i][15:0]) @(posedge clk);
         set_shutter(1'b0);
         if (m == 2'h3) begin
            pulse_read();
         end
      end
      // single frame and triggered modes read out once at the end
      if (m != 2'h3) begin
         pulse_read();
      end
   endtask
   // one enable window, msb first; return bit taken late in high phase
   task automatic send_word(input logic [15:0] w, output logic [15:0] back);
      back = 16'h0000;
      @(posedge clk);
      hkEnable <= 1'b1;
      for (int i = 15; i >= 0; i--) begin
         hkOutgoingData <= w[i];
         repeat (4) @(posedge clk);
         hkClk <= 1'b1;
         repeat (3) @(posedge clk);
         @(negedge clk);
         back = {back[14:0], hkReturnData};
         @(posedge clk);
         hkClk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      hkEnable <= 1'b0;
      // released data line must not keep showing the last bit
      hkOutgoingData <= ~w[0];
      repeat (12) @(posedge clk);
   endtask
   // read pulse, wide enough for the two flop input sync
   task automatic pulse_read();
      @(posedge clk);
      readPulse <= 1'b1;
      repeat (3) @(posedge clk);
      readPulse <= 1'b0;
   endtask
   task automatic set_shutter(input logic v);
      @(posedge clk);
      shutter <= v;
   endtask
endmodule

/* File: verification/palc_link_controller_test.sv */
// self checking bench for the pixel asic link controller
`timescale 1ns/10ps
`include "palc_params.svh"
module palc_link_controller_test;
   localparam int NW = 8;
   typedef struct packed {
      logic [15:0] cmd;
      logic [5:0] ctl;
   } palc_row_t;
   logic clk, rst_b, hkClk, hkEnable, hkOutgoingData, readPulse;
   logic shutter, countClock, hkReturnData, pixelParity, pixelSync;
   logic pixelDdrClock, asicPixelValid, asicPixelReady, asicShutter;
   logic countPolarity, testPulseEnable, dacWrite, adcRequest;
   logic tempRequest, ledD2, ledD3, acc, lastDdr;
   logic [1:0] asicIdBit, asicMode, frameClockHigh, frameClockLow;
   logic [1:0] asicInputEnable, asicDataIn, adcChannel;
   logic [27:0] pixelDataLanes, asicPixelPair, expWord;
   logic [2:0] dacChannel;
   logic [9:0] dacValue;
   logic [11:0] adcValue;
   logic [15:0] tempValue, back;
   logic [2:0][31:0] tbl;
   logic [27:0] sent[$];
   int fails, checkCount, nOut, dacPulses, adcPulses, tempPulses, t;
   logic fc;
   // {asicMode, countPolarity, testPulseEnable, ledD2, ledD3}
   palc_row_t rows [7] = '{'{16'h0200, 6'h38}, '{16'h0100, 6'h34},
      '{16'h1780, 6'h37}, '{16'h1680, 6'h35}, '{16'h1500, 6'h34},
      '{16'h0000, 6'h30}, '{16'h0300, 6'h3c}};

   palc_link_controller #(.READ_WORDS(NW)) dut_u (.clk(clk), .rst_b(rst_b),
      .hkClk(hkClk), .hkEnable(hkEnable), .hkOutgoingData(hkOutgoingData),
      .readPulse(readPulse), .shutter(shutter), .countClock(countClock),
      .asicIdBit(asicIdBit), .hkReturnData(hkReturnData),
      .pixelDataLanes(pixelDataLanes), .pixelParity(pixelParity),
      .pixelSync(pixelSync), .pixelDdrClock(pixelDdrClock),
      .asicPixelPair(asicPixelPair), .asicPixelValid(asicPixelValid),
      .asicPixelReady(asicPixelReady), .asicMode(asicMode),
      .frameClockHigh(frameClockHigh), .frameClockLow(frameClockLow),
      .asicInputEnable(asicInputEnable), .asicDataIn(asicDataIn),
      .asicShutter(asicShutter), .countPolarity(countPolarity),
      .testPulseEnable(testPulseEnable), .dacChannel(dacChannel),
      .dacValue(dacValue), .dacWrite(dacWrite), .adcChannel(adcChannel),
      .adcRequest(adcRequest), .tempRequest(tempRequest),
      .adcValue(adcValue), .tempValue(tempValue), .ledD2(ledD2),
      .ledD3(ledD3));
   palc_host_model host_u (.clk(clk), .hkClk(hkClk), .hkEnable(hkEnable),
      .hkOutgoingData(hkOutgoingData), .hkReturnData(hkReturnData),
      .readPulse(readPulse), .shutter(shutter), .countClock(countClock));

   // 100 MHz master clock from the host
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check_val(input logic [27:0] got, input logic [27:0] exp);
      checkCount++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // bounded wait for the mode lines
   task automatic wait_mode(input logic [1:0] m);
      int n;
      n = 0;
      while (asicMode !== m && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (n == 400) begin
         fails++;
         print_verdict();
      end
   endtask
   // routing command, then a pass-through window back to counting
   task automatic pass_window(input logic [15:0] c, input logic [1:0] m,
                              input logic [1:0] en);
      logic [15:0] b;
      host_u.send_word(c, b);
      @(negedge clk);
      check_val(28'(asicMode), 28'(m));
      fork
         host_u.send_word(16'hd8a5, b);
         begin
            repeat (38) @(negedge clk);
            check_val(28'({asicInputEnable, asicDataIn}), 28'({en, en}));
         end
      join
      if (m == `PALC_MODE_FSR) begin
         check_val(28'(b), 28'h000_ffff);
      end
      @(negedge clk);
      check_val(28'(asicMode), 28'h3);
   endtask
   // handshake sampled mid cycle, so no race with the ready logic
   always @(negedge clk) begin
      acc = asicPixelValid && asicPixelReady;
      dacPulses += int'(dacWrite === 1'b1);
      adcPulses += int'(adcRequest === 1'b1);
      tempPulses += int'(tempRequest === 1'b1);
   end
   // next pixel pair once the current one is taken
   always @(posedge clk) begin
      if (acc) begin
         sent.push_back(asicPixelPair);
         asicPixelPair <= asicPixelPair + 28'h111_1111;
      end
   end
   // every data clock edge carries one word
   always @(negedge clk) begin
      if (rst_b === 1'b1 && pixelDdrClock !== lastDdr) begin
         expWord = (sent.size() > 0) ? sent.pop_front() : ~pixelDataLanes;
         check_val(pixelDataLanes, expWord);
         check_val(28'(pixelParity), 28'(^expWord));
         check_val(28'(pixelSync), 28'(nOut == 0));
         nOut++;
      end
      lastDdr = pixelDdrClock;
   end
   initial begin
      rst_b = 1'b0;
      asicPixelPair = 28'h000_0001;
      asicPixelValid = 1'b0;
      adcValue = 12'ha5c;
      tempValue = 16'h8e31;
      asicIdBit = 2'h2;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      check_val(28'(asicMode), 28'h3);
      foreach (rows[i]) begin
         host_u.send_word(rows[i].cmd, back);
         @(negedge clk);
         check_val(28'({asicMode, countPolarity, testPulseEnable, ledD2,
                        ledD3}), 28'(rows[i].ctl));
      end
      for (int c = 0; c < 8; c++) begin
         host_u.send_word({3'h1, 3'(c), 10'(c * 93 + 7)}, back);
         @(negedge clk);
         check_val(28'({dacChannel, dacValue}), 28'({3'(c), 10'(c * 93 + 7)}));
      end
      check_val(28'(dacPulses), 28'h8);
      for (int c = 0; c < 4; c++) begin
         host_u.send_word({6'h03, 2'(c), 8'h5a}, back);
         @(negedge clk);
         check_val(28'(adcChannel), 28'(c));
      end
      host_u.send_word(16'h0f00, back);
      check_val(28'(back[11:0]), 28'(adcValue));
      host_u.send_word(16'h1000, back);
      host_u.send_word(16'h1000, back);
      check_val(28'(back), 28'(tempValue));
      check_val(28'({adcPulses[3:0], tempPulses[3:0]}), 28'h52);
      pass_window(16'h0400, `PALC_MODE_LOAD, 2'h1);
      pass_window(16'h0a00, `PALC_MODE_FSR, 2'h2);
      host_u.set_shutter(1'b1);
      repeat (8) @(negedge clk);
      check_val(28'({asicShutter, ledD3}), 28'h3);
      @(posedge clk);
      asicPixelValid <= 1'b1;
      for (int d = 0; d < 3; d++) begin
         if (d == 2) begin
            host_u.send_word(16'h0000, back);
         end
         tbl = (d == 0) ? {64'h0000_0000_0000_0000, 32'h0010_0000} :
            (d == 1) ? {32'h0000_0000, 32'h0003_0005, 32'h0004_0006} :
            {64'h0000_0000_0000_0000, 32'h0002_0004};
         nOut = 0;
         host_u.run_table(2'(d + 1), tbl);
         wait_mode(2'h0);
         check_val(28'({frameClockHigh, frameClockLow, asicShutter, ledD2}), 28'h31);
         wait_mode(2'h3);
         repeat (4) @(negedge clk);
         check_val(28'(nOut), 28'(NW));
      end
      // frame clock must follow the count clock again
      fc = frameClockHigh[0];
      t = 0;
      repeat (64) begin
         @(negedge clk);
         t += int'(frameClockHigh[0] !== fc);
         fc = frameClockHigh[0];
      end
      check_val(28'(t >= 14 && t <= 18), 28'h1);
      @(posedge clk);
      rst_b <= 1'b0;
      @(negedge clk);
      check_val(28'({asicMode, countPolarity, testPulseEnable}), 28'hc);
      // second release: the link must decode again from a clean state
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      host_u.send_word(16'h0300, back);
      @(negedge clk);
      check_val(28'({asicMode, countPolarity, testPulseEnable}), 28'hf);
      print_verdict();
   end
endmodule
